// ===== hdl/serial_flash_status_id_commands.sv
// Instruction handling of a serial flash: identification, status and write latch.
// Assumes a host SPI master drives csN, sclk and ioIn; sclk stops between frames.
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_params.svh"

module serial_flash_status_id_commands
   import flash_cmd_pkg::*;
#(
   parameter logic [7:0] MANUFACTURER_ID = 8'h5a, // Arbitrary value
   parameter logic [7:0] DEVICE_ID       = 8'ha5, // Arbitrary value
   parameter int unsigned STATUS_WRITE_CYCLES = `STATUS_WRITE_CYCLE_US * `CLOCK_MHZ,
   parameter int unsigned PROGRAM_CYCLES      = `PROGRAM_CYCLE_US * `CLOCK_MHZ
) (
   // System
   input  wire logic       clock,
   input  wire logic       resetn,
   // Array side
   input  wire logic [7:0] arrayByte,
   // Serial link
   input  wire logic       sclk,
   input  wire logic       csN,
   input  wire logic [3:0] ioIn,
   output logic      [3:0] ioOut,
   output logic      [3:0] ioOeN
);

   // ****************************************
   // Output plan per opcode
   // ****************************************
   function automatic out_plan_t plan_of(input logic [7:0] op);
      out_plan_t p;
      p = '{start: 6'h3f, lanes: 3'h0, sel: SEL_NONE, quad: 1'b0};
      case (op)
         `OP_READ_STATUS_LOW:  p = '{`START_STATUS, 3'h1, SEL_LOW, 1'b0};
         `OP_READ_STATUS_HIGH: p = '{`START_STATUS, 3'h1, SEL_HIGH, 1'b0};
         `OP_RELEASE_ID:       p = '{`START_RELEASE_ID, 3'h1, SEL_ID, 1'b0};
         `OP_ID_DUAL:          p = '{`START_ID_DUAL, 3'h2, SEL_PAIR, 1'b0};
         `OP_ID_QUAD:          p = '{`START_ID_QUAD, 3'h4, SEL_PAIR, 1'b1};
         `OP_WORD_READ_QUAD:   p = '{`START_WORD_READ, 3'h4, SEL_DATA, 1'b1};
         `OP_OCTAL_READ_QUAD:  p = '{`START_OCTAL_READ, 3'h4, SEL_DATA, 1'b1};
         default:              p = '{6'h3f, 3'h0, SEL_NONE, 1'b0};
      endcase
      return p;
   endfunction : plan_of

   function automatic logic [7:0] merge(input logic [7:0] old,
                                        input logic [7:0] wr,
                                        input logic [7:0] mask,
                                        input logic [7:0] otp);
      return (old & ~mask) | (wr & mask) | (old & otp);
   endfunction : merge

   // ****************************************
   // Reset release
   // ****************************************
   logic [1:0] rstPipe_ff;
   logic       rstSync;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rstPipe_ff <= 2'b00;
      end else begin
         rstPipe_ff <= {rstPipe_ff[0], 1'b1};
      end
   end

   assign rstSync = rstPipe_ff[1];

   // ****************************************
   // Link side, rising edge
   // ****************************************
   sys_t      sys_ff;
   frame_t    frame_ff;
   frame_t    nxt_frame;
   keep_t     keep_ff;
   keep_t     nxt_keep;
   drive_t    drive_ff;
   drive_t    nxt_drive;
   out_plan_t risePlan;
   out_plan_t fallPlan;
   logic      linkClear;

   // Chip select high ends the frame without needing a clock edge
   assign linkClear = csN | ~rstSync;
   assign risePlan  = plan_of(keep_ff.opcode);

   always_comb begin
      nxt_frame = frame_ff;
      nxt_keep  = keep_ff;
      if (frame_ff.cnt != 6'h3f) begin
         nxt_frame.cnt = frame_ff.cnt + 6'h1;
      end
      nxt_frame.phase = frame_ff.phase + 3'h1;
      nxt_keep.shift  = {keep_ff.shift[30:0], ioIn[0]};
      if (frame_ff.cnt == `POS_OPCODE_LAST) begin
         nxt_keep.opcode = {keep_ff.shift[6:0], ioIn[0]};
      end
      if (frame_ff.cnt == `POS_ADDR_LAST) begin
         nxt_keep.addr = {keep_ff.shift[22:0], ioIn[0]};
      end
      if (frame_ff.cnt >= `START_STATUS && frame_ff.cnt >= risePlan.start) begin
         nxt_frame.dataK = frame_ff.dataK + 4'h1;
      end
      nxt_keep.cnt   = nxt_frame.cnt;
      nxt_keep.phase = nxt_frame.phase;
   end

   always_ff @(posedge sclk or posedge linkClear) begin
      if (linkClear) begin
         frame_ff <= '0;
      end else begin
         frame_ff <= nxt_frame;
      end
   end

   // Holds the last frame for the system side; stable while csN is high
   always_ff @(posedge sclk or negedge rstSync) begin
      if (!rstSync) begin
         keep_ff <= '0;
      end else begin
         keep_ff <= nxt_keep;
      end
   end

   // ****************************************
   // Link side, falling edge drive
   // ****************************************
   logic [15:0] outWord;
   logic [15:0] outShifted;
   logic [3:0]  outAmt;
   logic        outGo;

   assign fallPlan = plan_of(keep_ff.opcode);

   always_comb begin
      nxt_drive = '{ioOut: 4'h0, ioOeN: 4'hf};
      case (fallPlan.sel)
         SEL_LOW:  outWord = {sys_ff.shadowLow, sys_ff.shadowLow};
         SEL_HIGH: outWord = {sys_ff.shadowHigh, sys_ff.shadowHigh};
         SEL_ID:   outWord = {DEVICE_ID, DEVICE_ID};
         SEL_PAIR: outWord = {MANUFACTURER_ID, DEVICE_ID};
         SEL_DATA: outWord = {sys_ff.shadowData, sys_ff.shadowData};
         default:  outWord = 16'h0000;
      endcase
      case (fallPlan.lanes)
         3'h2:    outAmt = {frame_ff.dataK[2:0], 1'b0};
         3'h4:    outAmt = {frame_ff.dataK[1:0], 2'b00};
         default: outAmt = frame_ff.dataK;
      endcase
      outShifted = outWord << outAmt;
      outGo = (frame_ff.cnt >= `START_STATUS) && (frame_ff.cnt >= fallPlan.start)
            && (fallPlan.lanes != 3'h0)
            && (!sys_ff.shadowLow[`LOW_BUSY_BIT] || fallPlan.sel == SEL_LOW
                || fallPlan.sel == SEL_HIGH)
            && (!fallPlan.quad || sys_ff.shadowHigh[`HIGH_QUAD_BIT]);
      if (outGo) begin
         case (fallPlan.lanes)
            3'h2: nxt_drive = '{{2'b00, outShifted[15:14]}, 4'b1100};
            3'h4: nxt_drive = '{outShifted[15:12], 4'b0000};
            default: nxt_drive = '{{2'b00, outShifted[15], 1'b0}, 4'b1101};
         endcase
      end
   end

   always_ff @(negedge sclk or posedge linkClear) begin
      if (linkClear) begin
         drive_ff <= '{ioOut: 4'h0, ioOeN: 4'hf};
      end else begin
         drive_ff <= nxt_drive;
      end
   end

   assign ioOut = drive_ff.ioOut;
   assign ioOeN = drive_ff.ioOeN;

   // ****************************************
   // System side: status and write control
   // ****************************************
   sys_t        nxt_sys;
   logic        frameEnd;
   logic        oneByte;
   logic        statusLen;
   logic        arrayStart;
   logic        securityOk;
   logic        isSecurity;
   logic [7:0]  statusLow;
   logic [7:0]  wrLow;
   logic [7:0]  wrHigh;
   logic [7:0]  newLow;
   logic [7:0]  newHigh;
   logic [23:0] addr;

   assign frameEnd  = sys_ff.csSync & ~sys_ff.csPrev;
   assign statusLow = {sys_ff.liveLow[7:2], sys_ff.latch, sys_ff.state == ST_BUSY};
   assign oneByte   = keep_ff.cnt == `LEN_STATUS_ONE;
   assign statusLen = oneByte || keep_ff.cnt == `LEN_STATUS_TWO;
   assign addr      = keep_ff.addr;
   assign wrLow     = oneByte ? keep_ff.shift[7:0] : keep_ff.shift[15:8];
   assign wrHigh    = oneByte ? (sys_ff.liveHigh & ~`HIGH_ONE_BYTE_CLEAR)
                              : keep_ff.shift[7:0];
   assign newLow    = merge(sys_ff.liveLow, wrLow, `LOW_WRITE_MASK, 8'h00);
   assign newHigh   = merge(sys_ff.liveHigh, wrHigh, `HIGH_WRITE_MASK,
                            `HIGH_OTP_MASK);
   assign isSecurity = keep_ff.opcode == `OP_SECURITY_ERASE
                    || keep_ff.opcode == `OP_SECURITY_PROGRAM;
   assign securityOk = !isSecurity
                    || (addr[23:16] == 8'h00 && addr[15:14] == 2'b00
                        && addr[11:8] == 4'h0 && addr[13:12] != 2'b00
                        && !sys_ff.liveHigh[3'(`LOCK_BASE_BIT) + 3'(addr[13:12])]);

   always_comb begin
      case (keep_ff.opcode)
         `OP_ERASE_4K, `OP_ERASE_32K, `OP_ERASE_64K, `OP_SECURITY_ERASE:
            arrayStart = keep_ff.cnt == `LEN_ADDR_ONLY;
         `OP_PAGE_PROGRAM, `OP_QUAD_PAGE_PROGRAM, `OP_SECURITY_PROGRAM:
            arrayStart = keep_ff.cnt >= `LEN_ADDR_DATA && keep_ff.phase == 3'h0;
         `OP_ERASE_CHIP_A, `OP_ERASE_CHIP_B:
            arrayStart = keep_ff.cnt == `LEN_SINGLE;
         default:
            arrayStart = 1'b0;
      endcase
   end

   always_comb begin
      nxt_sys        = sys_ff;
      nxt_sys.csMeta = csN;
      nxt_sys.csSync = sys_ff.csMeta;
      nxt_sys.csPrev = sys_ff.csSync;
      // Snapshot for the link side, frozen while a frame is open
      if (sys_ff.csSync) begin
         nxt_sys.shadowLow  = statusLow;
         nxt_sys.shadowHigh = sys_ff.liveHigh;
         nxt_sys.shadowData = arrayByte;
      end
      case (sys_ff.state)
         ST_BUSY: begin
            nxt_sys.timer = sys_ff.timer - 18'h1;
            if (sys_ff.timer == 18'h0) begin
               nxt_sys.state = ST_IDLE;
               nxt_sys.latch = 1'b0;
            end
         end
         ST_IDLE: begin
            if (frameEnd) begin
               nxt_sys.armVolatile = 1'b0;
               case (keep_ff.opcode)
                  `OP_WRITE_ENABLE: begin
                     if (keep_ff.cnt == `LEN_SINGLE) begin
                        nxt_sys.latch = 1'b1;
                     end
                  end
                  `OP_VOLATILE_ENABLE: begin
                     if (keep_ff.cnt == `LEN_SINGLE) begin
                        nxt_sys.armVolatile = 1'b1;
                     end
                  end
                  `OP_WRITE_DISABLE: begin
                     if (keep_ff.cnt == `LEN_SINGLE) begin
                        nxt_sys.latch = 1'b0;
                     end
                  end
                  `OP_WRITE_STATUS: begin
                     if (statusLen && (sys_ff.armVolatile || sys_ff.latch)) begin
                        nxt_sys.liveLow  = newLow;
                        nxt_sys.liveHigh = newHigh;
                        if (!sys_ff.armVolatile) begin
                           nxt_sys.state = ST_BUSY;
                           nxt_sys.timer = 18'(STATUS_WRITE_CYCLES - 1);
                        end
                     end
                  end
                  default: begin
                     if (arrayStart && sys_ff.latch && securityOk) begin
                        nxt_sys.state = ST_BUSY;
                        nxt_sys.timer = 18'(PROGRAM_CYCLES - 1);
                     end
                  end
               endcase
            end
         end
         default: nxt_sys.state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rstSync) begin
      if (!rstSync) begin
         sys_ff <= '{csMeta: 1'b1, csSync: 1'b1, csPrev: 1'b1, state: ST_IDLE,
                    timer: 18'h0, latch: 1'b0, armVolatile: 1'b0,
                    liveLow: `STATUS_RESET, liveHigh: `STATUS_RESET,
                    shadowLow: `STATUS_RESET, shadowHigh: `STATUS_RESET,
                    shadowData: 8'h00};
      end else begin
         sys_ff <= nxt_sys;
      end
   end

endmodule : serial_flash_status_id_commands
`default_nettype wire

// ===== hdl/flash_cmd_params.svh
// Constants of the serial flash status and identification command block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef FLASH_CMD_PARAMS_SVH
`define FLASH_CMD_PARAMS_SVH

// ****************************************
// Instruction codes
// ****************************************
`define OP_WRITE_ENABLE      8'h06
`define OP_VOLATILE_ENABLE   8'h50
`define OP_WRITE_DISABLE     8'h04
`define OP_READ_STATUS_LOW   8'h05
`define OP_READ_STATUS_HIGH  8'h35
`define OP_WRITE_STATUS      8'h01
`define OP_RELEASE_ID        8'hab
`define OP_ID_DUAL           8'h92
`define OP_ID_QUAD           8'h94
`define OP_WORD_READ_QUAD    8'he7
`define OP_OCTAL_READ_QUAD   8'he3
`define OP_SECURITY_ERASE    8'h44
`define OP_SECURITY_PROGRAM  8'h42
`define OP_PAGE_PROGRAM      8'h02
`define OP_QUAD_PAGE_PROGRAM 8'h32
`define OP_ERASE_4K          8'h20
`define OP_ERASE_32K         8'h52
`define OP_ERASE_64K         8'hd8
`define OP_ERASE_CHIP_A      8'hc7
`define OP_ERASE_CHIP_B      8'h60

// ****************************************
// Status fields
// ****************************************
`define STATUS_RESET         8'h00
`define LOW_WRITE_MASK       8'hfc
`define HIGH_WRITE_MASK      8'h7b
`define HIGH_OTP_MASK        8'h39
`define HIGH_ONE_BYTE_CLEAR  8'h42
`define HIGH_QUAD_BIT        1
`define LOW_BUSY_BIT         0
`define LOCK_BASE_BIT        2'd2

// ****************************************
// Frame positions, in serial clocks
// ****************************************
`define POS_OPCODE_LAST      6'd7
`define POS_ADDR_LAST        6'd31
`define START_STATUS         6'd8
`define START_RELEASE_ID     6'd32
`define START_ID_DUAL        6'd24
`define START_ID_QUAD        6'd20
`define START_WORD_READ      6'd18
`define START_OCTAL_READ     6'd16
`define LEN_SINGLE           6'd8
`define LEN_STATUS_ONE       6'd16
`define LEN_STATUS_TWO       6'd24
`define LEN_ADDR_ONLY        6'd32
`define LEN_ADDR_DATA        6'd40

// ****************************************
// Timing
// ****************************************
`define CLOCK_MHZ                 20
`define STATUS_WRITE_CYCLE_US     10000
`define PROGRAM_CYCLE_US          3000

`endif

// ===== hdl/flash_cmd_pkg.sv
// Types of the serial flash status and identification command block.
// Assumes the constants header is on the include path.
`include "flash_cmd_params.svh"

package flash_cmd_pkg;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_BUSY = 1'b1
   } sys_state_t;

   typedef enum logic [2:0] {
      SEL_NONE = 3'h0,
      SEL_LOW  = 3'h1,
      SEL_HIGH = 3'h2,
      SEL_ID   = 3'h3,
      SEL_PAIR = 3'h4,
      SEL_DATA = 3'h5
   } out_sel_t;

   typedef struct packed {
      logic [5:0] start;
      logic [2:0] lanes;
      out_sel_t   sel;
      logic       quad;
   } out_plan_t;

   typedef struct packed {
      logic        csMeta;
      logic        csSync;
      logic        csPrev;
      sys_state_t  state;
      logic [17:0] timer;
      logic        latch;
      logic        armVolatile;
      logic [7:0]  liveLow;
      logic [7:0]  liveHigh;
      logic [7:0]  shadowLow;
      logic [7:0]  shadowHigh;
      logic [7:0]  shadowData;
   } sys_t;

   typedef struct packed {
      logic [5:0] cnt;
      logic [2:0] phase;
      logic [3:0] dataK;
   } frame_t;

   typedef struct packed {
      logic [31:0] shift;
      logic [23:0] addr;
      logic [7:0]  opcode;
      logic [5:0]  cnt;
      logic [2:0]  phase;
   } keep_t;

   typedef struct packed {
      logic [3:0] ioOut;
      logic [3:0] ioOeN;
   } drive_t;

endpackage : flash_cmd_pkg

// ===== tb/flash_cmd_chk.sv
// Port checker of the status and identification command block.
// Assumes a bind from the bench top; lane values are judged by the serial frame count.
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_chk #(
   parameter logic [7:0] MANUFACTURER_ID = 8'h00,
   parameter logic [7:0] DEVICE_ID       = 8'h00
) (
   // System
   input wire logic       clock,
   input wire logic       resetn,
   input wire logic [7:0] arrayByte,
   // Serial link
   input wire logic       sclk,
   input wire logic       csN,
   input wire logic [3:0] ioIn,
   input wire logic [3:0] ioOut,
   input wire logic [3:0] ioOeN
);
   logic [6:0]  cnt_ff;
   logic [7:0]  opcode_ff;
   logic [5:0]  startPos;
   logic [15:0] idPair;
   logic        isStatus;
   assign idPair   = {MANUFACTURER_ID, DEVICE_ID};
   assign isStatus = (opcode_ff == 8'h05) || (opcode_ff == 8'h35);
   // ****************************************
   // Frame tracking
   // ****************************************
   always_comb begin
      case (opcode_ff)
         8'h05, 8'h35: startPos = 6'h08;
         8'hab:        startPos = 6'h20;
         8'h92:        startPos = 6'h18;
         8'h94:        startPos = 6'h14;
         8'he7:        startPos = 6'h12;
         8'he3:        startPos = 6'h10;
         default:      startPos = 6'h3f;
      endcase
   end
   always_ff @(posedge sclk or posedge csN) begin
      if (csN) begin
         cnt_ff    <= 7'h00;
         opcode_ff <= 8'h00;
      end else begin
         cnt_ff    <= (cnt_ff == 7'h7f) ? cnt_ff : cnt_ff + 7'h01;
         opcode_ff <= (cnt_ff < 7'h08) ? {opcode_ff[6:0], ioIn[0]} : opcode_ff;
      end
   end
   // ****************************************
   // Assertions
   // ****************************************
   property p_quiet;
      @(posedge sclk) disable iff (!resetn)
      (cnt_ff < {1'b0, startPos}) |-> ioOeN == 4'hf;
   endproperty
   a_quiet: assert property (p_quiet) else $error("lanes driven before data phase");
   property p_status_lanes;
      @(posedge sclk) disable iff (!resetn)
      (isStatus && cnt_ff >= 7'h08) |-> ioOeN == 4'hd;
   endproperty
   a_status_lanes: assert property (p_status_lanes) else $error("status not driven");
   property p_status_repeat;
      @(posedge sclk) disable iff (!resetn)
      (isStatus && cnt_ff >= 7'h10) |-> ioOut[1] == $past(ioOut[1], 8);
   endproperty
   a_status_repeat: assert property (p_status_repeat) else $error("status not repeated");
   property p_release_id;
      @(posedge sclk) disable iff (!resetn)
      (opcode_ff == 8'hab && cnt_ff >= 7'h20) |-> ioOeN == 4'hf ||
         (ioOeN == 4'hd && ioOut[1] == DEVICE_ID[3'h7 - cnt_ff[2:0]]);
   endproperty
   a_release_id: assert property (p_release_id) else $error("device id bit wrong");
   property p_dual_id;
      @(posedge sclk) disable iff (!resetn)
      (opcode_ff == 8'h92 && cnt_ff >= 7'h18) |-> ioOeN == 4'hf ||
         (ioOeN == 4'hc && ioOut[1:0] == idPair[4'hf - {cnt_ff[2:0], 1'b0} -: 2]);
   endproperty
   a_dual_id: assert property (p_dual_id) else $error("dual id pair wrong");
   property p_quad_id;
      @(posedge sclk) disable iff (!resetn)
      (opcode_ff == 8'h94 && cnt_ff >= 7'h14) |-> ioOeN == 4'hf ||
         (ioOeN == 4'h0 && ioOut == idPair[4'hf - {cnt_ff[1:0], 2'b00} -: 4]);
   endproperty
   a_quad_id: assert property (p_quad_id) else $error("quad id nibble wrong");
   property p_word_read;
      @(posedge sclk) disable iff (!resetn)
      ((opcode_ff == 8'he7 && cnt_ff >= 7'h12) || (opcode_ff == 8'he3 && cnt_ff >= 7'h10))
         |-> ioOeN == 4'hf ||
         (ioOeN == 4'h0 && ioOut == (cnt_ff[0] ? arrayByte[3:0] : arrayByte[7:4]));
   endproperty
   a_word_read: assert property (p_word_read) else $error("quad read nibble wrong");
   property p_idle_release;
      @(posedge clock) disable iff (!resetn)
      csN |-> ioOeN == 4'hf;
   endproperty
   a_idle_release: assert property (p_idle_release) else $error("lanes held when idle");
   property p_lane_sets;
      @(posedge clock) disable iff (!resetn)
      ioOeN inside {4'hf, 4'hd, 4'hc, 4'h0};
   endproperty
   a_lane_sets: assert property (p_lane_sets) else $error("odd lane enable set");
endmodule : flash_cmd_chk
`default_nettype wire

// ===== tb/flash_host_model.sv
// Host SPI controller model, mode 0, serial clock only inside frames.
// Assumes the bench calls frame() and leaves chip select high between calls.
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
   // System
   input  wire logic       clock,
   // Serial link
   output var  logic       csN,
   output var  logic       sclk,
   output wire logic [3:0] ioIn,
   input  wire logic [3:0] ioOut,
   input  wire logic [3:0] ioOeN,
   // Observation
   output var  logic       drove
);
   logic [3:0] hostOut = 4'h0;
   logic [3:0] hostOe  = 4'h0;
   logic       junk    = 1'b0;
   initial csN   = 1'b1;
   initial sclk  = 1'b0;
   initial drove = 1'b0;
   // Released lanes toggle so a stale level never reads as data
   always @(sclk) junk <= ~junk;
   assign ioIn = (~ioOeN & ioOut) | (ioOeN & hostOe & hostOut) | (ioOeN & ~hostOe & {4{junk}});
   // ****************************************
   // One frame: opcode, tail on tLanes, then read on rLanes
   // ****************************************
   task automatic frame(input logic [7:0] op, input logic [47:0] tail, input int tClk,
                        input int tLanes, input int rClk, input int rLanes,
                        output logic [63:0] rd);
      logic [55:0] seq;
      int          k;
      seq   = {op, tail};
      rd    = 64'h0;
      drove = 1'b0;
      @(posedge clock);
      csN <= 1'b0;
      #4;
      for (int n = 0; n < 8 + tClk + rClk; n++) begin
         k       = (n < 8) ? 1 : (n < 8 + tClk) ? tLanes : 0;
         hostOe  = 4'h0;
         hostOut = 4'h0;
         for (int i = 0; i < k; i++) begin
            hostOut[k - 1 - i] = seq[55 - i];
            hostOe[k - 1 - i]  = 1'b1;
         end
         seq = seq << k;
         #3 sclk = 1'b1;
         if (ioOeN !== 4'hf) drove = 1'b1;
         if (n >= 8 + tClk) begin
            rd = (rLanes == 4) ? {rd[59:0], ioIn} :
                 (rLanes == 2) ? {rd[61:0], ioIn[1:0]} : {rd[62:0], ioIn[1]};
         end
         #3 sclk = 1'b0;
      end
      hostOe = 4'h0;
      @(posedge clock);
      csN <= 1'b1;
      repeat (6) @(posedge clock);
   endtask : frame
endmodule : flash_host_model
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench of the status and identification command block.
// Assumes the host model drives the link; status write 100 and program 30 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [7:0] MF = 8'h3c; // Arbitrary value
   localparam logic [7:0] DV = 8'hc3; // Arbitrary value
   logic        clock = 1'b0;
   logic        resetn = 1'b0;
   logic [7:0]  arrayByte = 8'h96;
   wire logic   csN, sclk, drove;
   wire logic [3:0] ioIn, ioOut, ioOeN;
   logic [63:0] rd;
   int          badCount = 0;
   int          checkCount = 0;
   int          cycles = 0;
   always #25 clock = ~clock;
   serial_flash_status_id_commands #(.MANUFACTURER_ID(MF), .DEVICE_ID(DV),
      .STATUS_WRITE_CYCLES(100), .PROGRAM_CYCLES(30)) dut_u (
      .clock(clock), .resetn(resetn), .arrayByte(arrayByte), .sclk(sclk),
      .csN(csN), .ioIn(ioIn), .ioOut(ioOut), .ioOeN(ioOeN));
   flash_host_model host_u (.clock(clock), .csN(csN), .sclk(sclk), .ioIn(ioIn),
      .ioOut(ioOut), .ioOeN(ioOeN), .drove(drove));
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input logic ok, input string what);
      checkCount++;
      if (ok !== 1'b1) begin
         badCount++;
         $display("ERROR %0t %s", $time, what);
      end
   endtask : check
   task automatic cmd(input logic [7:0] op, input logic [47:0] tail, input int tClk);
      host_u.frame(op, tail, tClk, 1, 0, 1, rd);
   endtask : cmd
   task automatic status(input logic [7:0] op, input logic [7:0] exp, input logic [7:0] mask);
      host_u.frame(op, 48'h0, 0, 1, 16, 1, rd);
      check((((rd[15:0] ^ {exp, exp}) & {mask, mask}) === 16'h0) && drove === 1'b1,
            "status byte wrong");
   endtask : status
   task automatic wrStatus(input logic vol, input logic [15:0] val, input int bits);
      cmd(vol ? 8'h50 : 8'h06, 48'h0, 0);
      cmd(8'h01, {val, 32'h0}, bits);
   endtask : wrStatus
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_latch;
      status(8'h05, 8'h00, 8'hff);
      status(8'h35, 8'h00, 8'hff);
      cmd(8'h06, 48'h0, 0);
      status(8'h05, 8'h02, 8'hff);
      cmd(8'h04, 48'h0, 0);
      status(8'h05, 8'h00, 8'hff);
      cmd(8'h06, 48'h0, 1);
      status(8'h05, 8'h00, 8'hff);
      cmd(8'h50, 48'h0, 0);
      status(8'h05, 8'h00, 8'hff);
      cmd(8'h50, 48'h0, 0);
      cmd(8'h04, 48'h0, 0);
      cmd(8'h01, {16'h1c02, 32'h0}, 16);
      status(8'h05, 8'h00, 8'hff);
      $display("latch test done");
   endtask : t_latch
   task automatic t_write;
      wrStatus(1'b0, 16'h1f86, 16);
      host_u.frame(8'hab, 48'h0, 24, 1, 8, 1, rd);
      check(drove === 1'b0, "served while busy");
      status(8'h05, 8'h03, 8'h03);
      repeat (120) @(posedge clock);
      status(8'h05, 8'h1c, 8'hff);
      status(8'h35, 8'h02, 8'hff);
      wrStatus(1'b0, 16'h1c42, 16);
      repeat (120) @(posedge clock);
      status(8'h35, 8'h42, 8'hff);
      wrStatus(1'b1, 16'h0400, 8);
      status(8'h05, 8'h04, 8'hff);
      status(8'h35, 8'h00, 8'hff);
      wrStatus(1'b0, 16'hfc00, 12);
      status(8'h05, 8'h04, 8'hfd);
      cmd(8'h04, 48'h0, 0);
      $display("status write test done");
   endtask : t_write
   task automatic t_ids;
      host_u.frame(8'h94, 48'h0, 12, 4, 8, 4, rd);
      check(drove === 1'b0, "quad id without quad enable");
      wrStatus(1'b1, 16'h0402, 16);
      status(8'h35, 8'h02, 8'hff);
      host_u.frame(8'hab, 48'h0, 24, 1, 16, 1, rd);
      check(rd[15:0] === {DV, DV}, "release id wrong");
      host_u.frame(8'h92, 48'h0, 16, 2, 16, 2, rd);
      check(rd[31:0] === {MF, DV, MF, DV}, "dual id wrong");
      host_u.frame(8'h94, 48'h0, 12, 4, 8, 4, rd);
      check(rd[31:0] === {MF, DV, MF, DV}, "quad id wrong");
      host_u.frame(8'he7, {24'h000012, 24'h0}, 10, 4, 4, 4, rd);
      check(rd[15:0] === {arrayByte, arrayByte}, "word read wrong");
      host_u.frame(8'he3, {24'h000030, 24'h0}, 8, 4, 4, 4, rd);
      check(rd[15:0] === {arrayByte, arrayByte}, "octal read wrong");
      $display("id test done");
   endtask : t_ids
   task automatic t_program;
      logic [7:0]  ops[5] = '{8'h02, 8'h20, 8'h44, 8'h42, 8'hc7};
      logic [47:0] tails[5] = '{{24'h001000, 24'ha50000}, {24'h002000, 24'h0},
                                {24'h002000, 24'h0}, {24'h003000, 24'h5a0000}, 48'h0};
      int          clks[5] = '{32, 24, 24, 32, 0};
      for (int i = 0; i < 5; i++) begin
         cmd(8'h06, 48'h0, 0);
         cmd(ops[i], tails[i], clks[i]);
         status(8'h05, 8'h03, 8'h03);
         repeat (50) @(posedge clock);
         status(8'h05, 8'h00, 8'h03);
      end
      cmd(8'h06, 48'h0, 0);
      cmd(8'h44, {24'h012000, 24'h0}, 24);
      status(8'h05, 8'h02, 8'h03);
      cmd(8'h04, 48'h0, 0);
      wrStatus(1'b0, 16'h0008, 16);
      repeat (120) @(posedge clock);
      wrStatus(1'b1, 16'h0000, 16);
      status(8'h35, 8'h08, 8'hff);
      $display("program test done");
   endtask : t_program
   // ****************************************
   // Sequence and verdict
   // ****************************************
   task automatic conclude;
      $display("checks %0d mismatches %0d", checkCount, badCount);
      if (badCount == 0 && checkCount > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         badCount++;
         $display("ERROR %0t run timed out", $time);
         conclude();
      end
   end
   initial begin
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
      repeat (8) @(posedge clock);
      t_latch();
      t_write();
      t_ids();
      t_program();
      conclude();
   end
endmodule : tb
bind serial_flash_status_id_commands flash_cmd_chk #(.MANUFACTURER_ID(MANUFACTURER_ID),
   .DEVICE_ID(DEVICE_ID)) chk_u (.clock(clock), .resetn(resetn), .arrayByte(arrayByte),
   .sclk(sclk), .csN(csN), .ioIn(ioIn), .ioOut(ioOut), .ioOeN(ioOeN));
`default_nettype wire
